// ### verilog/sas_defines.svh
// offsets, field positions, reset values and limits of the signed accumulator shifter
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH

`define SAS_MODE_OFF 8'h00
`define SAS_CMD_OFF 8'h04
`define SAS_TREG_OFF 8'h08
`define SAS_STAT_OFF 8'h0c
`define SAS_AUX_OFF 8'h10
`define SAS_ACC_REGION 3'h1

`define SAS_MODE_WIDE 0
`define SAS_MODE_SXM 1
`define SAS_MODE_ACC_SATURATE_ENABLE 2
`define SAS_MODE_LEGACY 3
`define SAS_MODE_ADDR_UNIT_SATURATE_ENABLE 4
`define SAS_MODE_RST 5'h00

`define SAS_CMD_SRC_LSB 0
`define SAS_CMD_DST_LSB 2
`define SAS_CMD_DST_GIVEN 4
`define SAS_CMD_CAPTURE 5
`define SAS_CMD_USE_IMM 6
`define SAS_CMD_IMM_LSB 7
`define SAS_CMD_AUX_OP 13
`define SAS_CMD_AUX_LEFT 14

`define SAS_STAT_OVF_LSB 0
`define SAS_STAT_CARRY 4
`define SAS_STAT_AUX_OVF 5

`define SAS_AMT_MAX16 16'h001f
`define SAS_AMT_MIN16 16'hffe0
`define SAS_AMT_MAX 7'h1f
`define SAS_AMT_MIN 7'h60
`define SAS_LEGACY_FOLD 7'h10

`define SAS_SAT_NARROW_POS 40'h00_7fff_ffff
`define SAS_SAT_NARROW_NEG 40'hff_8000_0000
`define SAS_SAT_WIDE_POS 40'h7f_ffff_ffff
`define SAS_SAT_WIDE_NEG 40'h80_0000_0000
`define SAS_SAT_AUX_POS 16'h7fff
`define SAS_SAT_AUX_NEG 16'h8000

`define SAS_RESP_OKAY 2'h0
`define SAS_RESP_SLVERR 2'h2

`endif

// ### verilog/sas_pkg.sv
// types shared by the signed accumulator shifter modules
package sas_pkg;

typedef logic [39:0] sas_acc_type;

typedef enum logic [1:0] {
	SAS_WR_IDLE = 2'h1,
	SAS_WR_RESP = 2'h2
} sas_wr_state_type;

typedef enum logic [1:0] {
	SAS_RD_IDLE = 2'h1,
	SAS_RD_DATA = 2'h2
} sas_rd_state_type;

endpackage

// ### verilog/sas_amount.sv
// shift amount conditioning: clamping, legacy folding and immediate extension
`timescale 1ns/10ps
`include "sas_defines.svh"

module sas_amount
	import sas_pkg::*;
(
	input wire logic [15:0] treg_val,
	input wire logic [5:0] imm_field,
	input wire logic use_imm,
	input wire logic legacy,
	output logic [6:0] amount,
	output logic clamped
);

always_comb begin
	amount = 7'h00;
	clamped = 1'b0;
	if (use_imm) begin
		amount = {imm_field[5], imm_field};
	end else if (legacy) begin
		// six low bits, fold -32..-17 by 16
		amount = {treg_val[5], treg_val[5:0]};
		if (treg_val[5] && !treg_val[4]) begin
			amount = amount + `SAS_LEGACY_FOLD;
		end
	end else if (!treg_val[15] && treg_val > `SAS_AMT_MAX16) begin
		amount = `SAS_AMT_MAX;
		clamped = 1'b1;
	end else if (treg_val[15] && treg_val < `SAS_AMT_MIN16) begin
		amount = `SAS_AMT_MIN;
		clamped = 1'b1;
	end else begin
		amount = treg_val[6:0];
	end
end

endmodule

// ### verilog/sas_aux_alu.sv
// single-bit signed shift of the 16-bit auxiliary register
`timescale 1ns/10ps
`include "sas_defines.svh"

module sas_aux_alu
	import sas_pkg::*;
(
	input wire logic [15:0] aux_in,
	input wire logic left,
	input wire logic addr_unit_saturate_enable,
	output logic [15:0] aux_out,
	output logic ovf
);

always_comb begin
	aux_out = {aux_in[15], aux_in[15:1]};
	ovf = 1'b0;
	if (left) begin
		aux_out = {aux_in[14:0], 1'b0};
		ovf = aux_in[15] ^ aux_in[14];
		if (ovf && addr_unit_saturate_enable) begin
			aux_out = aux_in[15] ? `SAS_SAT_AUX_NEG : `SAS_SAT_AUX_POS;
		end
	end
end

endmodule

// ### verilog/sas_core.sv
// signed accumulator barrel shifter with axi4-lite register access
`timescale 1ns/10ps
`include "sas_defines.svh"

module sas_core
	import sas_pkg::*;
(
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);

typedef struct packed {
	logic aw_have;
	logic [7:0] awaddr;
	logic w_have;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	sas_wr_state_type wr_state;
	logic [1:0] bresp;
	sas_rd_state_type rd_state;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic [4:0] mode;
	logic [15:0] treg;
	logic [15:0] aux;
	sas_acc_type [3:0] acc;
	logic [3:0] acc_ovf;
	logic carry;
	logic aux_ovf;
} sas_state_type;

sas_state_type state_reg;
sas_state_type state_next;

function automatic logic [31:0] sas_merge(input logic [31:0] old_v, input logic [31:0] new_v,
	input logic [3:0] strb);
	logic [31:0] res;
	res = old_v;
	for (int i = 0; i < 4; i++) begin
		if (strb[i]) begin
			res[8*i +: 8] = new_v[8*i +: 8];
		end
	end
	return res;
endfunction

logic wr_fire;
logic cmd_fire;
logic acc_op;
logic [1:0] src_idx;
logic [1:0] dst_idx;
logic capture;
logic use_imm;
logic legacy;
logic wide_eff;
logic sxm;
logic acc_saturate_enable;
logic [6:0] amount;
logic clamped;
logic shift_left;
logic [5:0] n_left;
logic [5:0] n_right;
sas_acc_type src_val;
sas_acc_type shin;
logic [79:0] ext;
logic [79:0] prod;
logic [79:0] rsh;
logic ovf_det;
logic cbit;
sas_acc_type shift_res;
logic [15:0] aux_res;
logic aux_ovf_res;
logic wr_acc_region;
logic rd_acc_region;

assign wr_fire = state_reg.aw_have && state_reg.w_have && state_reg.wr_state == SAS_WR_IDLE;
assign cmd_fire = wr_fire && state_reg.awaddr == `SAS_CMD_OFF;
// accumulator destinations go through the 40-bit shifter
assign acc_op = cmd_fire && !state_reg.wdata[`SAS_CMD_AUX_OP];
assign src_idx = state_reg.wdata[`SAS_CMD_SRC_LSB +: 2];
// no destination given: result returns to the source
assign dst_idx = state_reg.wdata[`SAS_CMD_DST_GIVEN] ? state_reg.wdata[`SAS_CMD_DST_LSB +: 2] : src_idx;
assign capture = state_reg.wdata[`SAS_CMD_CAPTURE];
assign use_imm = state_reg.wdata[`SAS_CMD_USE_IMM];
assign legacy = state_reg.mode[`SAS_MODE_LEGACY];
// legacy mode behaves as wide mode
assign wide_eff = state_reg.mode[`SAS_MODE_WIDE] || legacy;
assign sxm = state_reg.mode[`SAS_MODE_SXM];
assign acc_saturate_enable = state_reg.mode[`SAS_MODE_ACC_SATURATE_ENABLE];

sas_amount amount_unit (
	.treg_val(state_reg.treg),
	.imm_field(state_reg.wdata[`SAS_CMD_IMM_LSB +: 6]),
	.use_imm(use_imm),
	.legacy(legacy),
	.amount(amount),
	.clamped(clamped)
);

assign shift_left = !amount[6];
assign n_left = amount[5:0];
assign n_right = 6'(7'h00 - amount);
assign src_val = state_reg.acc[src_idx];

// guard bits replaced in narrow mode
assign shin = wide_eff ? src_val : {(sxm ? {8{src_val[31]}} : 8'h00), src_val[31:0]};
// 40-bit operand sign-extended for the overflow check
assign ext = {{40{shin[39]}}, shin};
// left shift inserts zeros at bit 0
assign prod = ext << n_left;
assign rsh = 80'($signed({shin, 40'h00_0000_0000}) >>> n_right);

// bits above the sign position must match
always_comb begin
	ovf_det = 1'b0;
	if (shift_left && !legacy) begin
		if (wide_eff) begin
			ovf_det = (|prod[79:39]) && !(&prod[79:39]);
		end else begin
			ovf_det = (|prod[79:31]) && !(&prod[79:31]);
		end
	end
end

// carry from bit 0 on right, sign position on left
assign cbit = shift_left ? (wide_eff ? prod[40] : prod[32]) : rsh[39];

always_comb begin
	shift_res = shift_left ? prod[39:0] : rsh[79:40];
	if (ovf_det && acc_saturate_enable) begin
		if (wide_eff) begin
			shift_res = shin[39] ? `SAS_SAT_WIDE_NEG : `SAS_SAT_WIDE_POS;
		end else begin
			shift_res = shin[39] ? `SAS_SAT_NARROW_NEG : `SAS_SAT_NARROW_POS;
		end
	end
end

// auxiliary destinations use the 16-bit alu
sas_aux_alu aux_unit (
	.aux_in(state_reg.aux),
	.left(state_reg.wdata[`SAS_CMD_AUX_LEFT]),
	.addr_unit_saturate_enable(state_reg.mode[`SAS_MODE_ADDR_UNIT_SATURATE_ENABLE]),
	.aux_out(aux_res),
	.ovf(aux_ovf_res)
);

assign wr_acc_region = state_reg.awaddr[7:5] == `SAS_ACC_REGION && state_reg.awaddr[1:0] == 2'h0;
assign rd_acc_region = s_axi_araddr[7:5] == `SAS_ACC_REGION && s_axi_araddr[1:0] == 2'h0;

assign s_axi_awready = !state_reg.aw_have && state_reg.wr_state == SAS_WR_IDLE;
assign s_axi_wready = !state_reg.w_have && state_reg.wr_state == SAS_WR_IDLE;
assign s_axi_bvalid = state_reg.wr_state == SAS_WR_RESP;
assign s_axi_bresp = state_reg.bresp;
assign s_axi_arready = state_reg.rd_state == SAS_RD_IDLE;
assign s_axi_rvalid = state_reg.rd_state == SAS_RD_DATA;
assign s_axi_rdata = state_reg.rdata;
assign s_axi_rresp = state_reg.rresp;

always_comb begin
	logic [31:0] tmp;
	tmp = 32'h0000_0000;
	state_next = state_reg;
	if (s_axi_awvalid && s_axi_awready) begin
		state_next.aw_have = 1'b1;
		state_next.awaddr = s_axi_awaddr;
	end
	if (s_axi_wvalid && s_axi_wready) begin
		state_next.w_have = 1'b1;
		state_next.wdata = s_axi_wdata;
		state_next.wstrb = s_axi_wstrb;
	end
	if (wr_fire) begin
		state_next.wr_state = SAS_WR_RESP;
		state_next.bresp = `SAS_RESP_OKAY;
		if (wr_acc_region) begin
			if (state_reg.awaddr[2]) begin
				tmp = sas_merge({24'h00_0000, state_reg.acc[state_reg.awaddr[4:3]][39:32]},
					state_reg.wdata, state_reg.wstrb);
				state_next.acc[state_reg.awaddr[4:3]][39:32] = tmp[7:0];
			end else begin
				state_next.acc[state_reg.awaddr[4:3]][31:0] = sas_merge(
					state_reg.acc[state_reg.awaddr[4:3]][31:0], state_reg.wdata, state_reg.wstrb);
			end
		end else begin
			case (state_reg.awaddr)
				`SAS_MODE_OFF: begin
					tmp = sas_merge({27'h000_0000, state_reg.mode}, state_reg.wdata, state_reg.wstrb);
					state_next.mode = tmp[4:0];
				end
				`SAS_TREG_OFF: begin
					tmp = sas_merge({16'h0000, state_reg.treg}, state_reg.wdata, state_reg.wstrb);
					state_next.treg = tmp[15:0];
				end
				`SAS_AUX_OFF: begin
					tmp = sas_merge({16'h0000, state_reg.aux}, state_reg.wdata, state_reg.wstrb);
					state_next.aux = tmp[15:0];
				end
				`SAS_STAT_OFF: begin
					// write one to clear; no flag can be set by the same write
					if (state_reg.wstrb[0]) begin
						state_next.acc_ovf = state_reg.acc_ovf & ~state_reg.wdata[`SAS_STAT_OVF_LSB +: 4];
						if (state_reg.wdata[`SAS_STAT_CARRY]) begin
							state_next.carry = 1'b0;
						end
						if (state_reg.wdata[`SAS_STAT_AUX_OVF]) begin
							state_next.aux_ovf = 1'b0;
						end
					end
				end
				`SAS_CMD_OFF: begin
					// destination, flags and carry update at one edge
					if (state_reg.wdata[`SAS_CMD_AUX_OP]) begin
						state_next.aux = aux_res;
						if (aux_ovf_res) begin
							state_next.aux_ovf = 1'b1;
						end
					end else begin
						state_next.acc[dst_idx] = shift_res;
						// overflow is sticky on the destination
						if (clamped || ovf_det) begin
							state_next.acc_ovf[dst_idx] = 1'b1;
						end
						// capture variants only; zero count clears
						if (capture) begin
							state_next.carry = (amount == 7'h00) ? 1'b0 : cbit;
						end
					end
				end
				default: begin
					state_next.bresp = `SAS_RESP_SLVERR;
				end
			endcase
		end
	end
	if (state_reg.wr_state == SAS_WR_RESP && s_axi_bready) begin
		state_next.wr_state = SAS_WR_IDLE;
		state_next.aw_have = 1'b0;
		state_next.w_have = 1'b0;
	end
	if (state_reg.rd_state == SAS_RD_IDLE && s_axi_arvalid) begin
		state_next.rd_state = SAS_RD_DATA;
		state_next.rresp = `SAS_RESP_OKAY;
		state_next.rdata = 32'h0000_0000;
		if (rd_acc_region) begin
			if (s_axi_araddr[2]) begin
				state_next.rdata = {24'h00_0000, state_reg.acc[s_axi_araddr[4:3]][39:32]};
			end else begin
				state_next.rdata = state_reg.acc[s_axi_araddr[4:3]][31:0];
			end
		end else begin
			case (s_axi_araddr)
				`SAS_MODE_OFF: state_next.rdata = {27'h000_0000, state_reg.mode};
				`SAS_CMD_OFF: state_next.rdata = 32'h0000_0000;
				`SAS_TREG_OFF: state_next.rdata = {16'h0000, state_reg.treg};
				`SAS_AUX_OFF: state_next.rdata = {16'h0000, state_reg.aux};
				`SAS_STAT_OFF: state_next.rdata = {26'h000_0000, state_reg.aux_ovf, state_reg.carry,
					state_reg.acc_ovf};
				default: state_next.rresp = `SAS_RESP_SLVERR;
			endcase
		end
	end else if (state_reg.rd_state == SAS_RD_DATA && s_axi_rready) begin
		state_next.rd_state = SAS_RD_IDLE;
	end
end

always_ff @(posedge mclk) begin
	if (sys_rst) begin
		state_reg <= '0;
		state_reg.wr_state <= SAS_WR_IDLE;
		state_reg.rd_state <= SAS_RD_IDLE;
		state_reg.mode <= `SAS_MODE_RST;
	end else begin
		state_reg <= state_next;
	end
end

clamp_range_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && !use_imm && !legacy && !state_reg.treg[15] && state_reg.treg > 16'h001f
	|-> amount == 7'h1f && clamped)
	else $error("clamped amount is not +31");

clamp_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && clamped |=> state_reg.acc_ovf[$past(dst_idx)])
	else $error("clamping did not set overflow flag");

guard_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && !wide_eff && !sxm && amount[6] |=> state_reg.acc[$past(dst_idx)][39:32] == 8'h00)
	else $error("guard bits not zero after narrow right shift");

zero_fill_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && shift_left && amount != 7'h00 && !ovf_det |=> !state_reg.acc[$past(dst_idx)][0])
	else $error("left shift did not fill bit 0 with zero");

carry_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && capture && amount == 7'h00 |=> !state_reg.carry)
	else $error("zero count did not clear carry");

carry_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
	cmd_fire && !capture |=> state_reg.carry == $past(state_reg.carry))
	else $error("plain shift changed carry");

sat_narrow_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && !wide_eff && acc_saturate_enable && ovf_det && shin[39]
	|=> state_reg.acc[$past(dst_idx)] == 40'hff_8000_0000 && state_reg.acc_ovf[$past(dst_idx)])
	else $error("narrow negative saturation wrong");

sat_wide_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && wide_eff && acc_saturate_enable && ovf_det && !shin[39]
	|=> state_reg.acc[$past(dst_idx)] == 40'h7f_ffff_ffff)
	else $error("wide positive saturation wrong");

legacy_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
	acc_op && legacy |-> !ovf_det ##1 state_reg.acc_ovf == $past(state_reg.acc_ovf))
	else $error("legacy mode reported overflow");

write_resp_a: assert property (@(posedge mclk) disable iff (sys_rst)
	wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
	else $error("write response not given one cycle after execution");

endmodule

// ### bench/sas_host_model.sv
// axi4-lite master standing in for the cpu side of the shifter
`timescale 1ns/10ps

module sas_host_model (
	input wire logic mclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	logic hang;

	initial begin
		hang = 1'b0;
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'h0;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b0;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b0;
	end

	// ready is looked at mid-cycle, where it is settled until the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw_a, w_a, got;
		n = 0;
		got = 1'b0;
		r = 2'h3;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!got && n < 60) begin
			@(negedge mclk);
			aw_a = s_axi_awvalid && s_axi_awready;
			w_a = s_axi_wvalid && s_axi_wready;
			got = s_axi_bvalid;
			if (got)
				r = s_axi_bresp;
			@(posedge mclk);
			if (aw_a)
				s_axi_awvalid <= 1'b0;
			if (w_a)
				s_axi_wvalid <= 1'b0;
			if (got)
				s_axi_bready <= 1'b0;
			n++;
		end
		if (!got)
			hang = 1'b1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar_a, got;
		n = 0;
		got = 1'b0;
		d = 32'h0;
		r = 2'h3;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!got && n < 60) begin
			@(negedge mclk);
			ar_a = s_axi_arvalid && s_axi_arready;
			got = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge mclk);
			if (ar_a)
				s_axi_arvalid <= 1'b0;
			if (got)
				s_axi_rready <= 1'b0;
			n++;
		end
		if (!got)
			hang = 1'b1;
	endtask
endmodule

// ### bench/sas_core_tb_top.sv
// self-checking bench for the signed accumulator shifter
`timescale 1ns/10ps
`include "sas_defines.svh"

module sas_core_tb_top;
	import sas_pkg::*;

	`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
		$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] awaddr, araddr;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int errors = 0;
	int samples_checked = 0;

	always #25 mclk = ~mclk;

	sas_host_model u_host (.mclk(mclk), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	sas_core u_dut (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	task automatic final_report();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic hang_check();
		if (u_host.hang) begin
			errors++;
			$display("[ERR] %0t bus handshake timed out", $time);
			final_report();
		end
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] re = `SAS_RESP_OKAY);
		logic [1:0] r;
		u_host.wr(a, d, r);
		hang_check();
		`CHK(r, re)
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re = `SAS_RESP_OKAY);
		logic [31:0] d;
		logic [1:0] r;
		u_host.rd(a, d, r);
		hang_check();
		`CHK(r, re)
		`CHK(d, e)
	endtask

	task automatic setacc(input int i, input sas_acc_type v);
		w(8'(32'h20 + 8 * i), v[31:0]);
		w(8'(32'h24 + 8 * i), {24'h0, v[39:32]});
	endtask

	task automatic chkacc(input int i, input sas_acc_type v);
		rchk(8'(32'h20 + 8 * i), v[31:0]);
		rchk(8'(32'h24 + 8 * i), {24'h0, v[39:32]});
	endtask

	// command word: source, destination, destination given, capture, immediate, amount
	function automatic logic [31:0] mk(input logic [1:0] s, input logic [1:0] d, input logic g,
		input logic c, input logic im, input logic [5:0] v);
		mk = {19'h0, v, im, c, g, d, s};
	endfunction

	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'b0;
		@(posedge mclk);
		rchk(`SAS_MODE_OFF, 32'h0);
		rchk(`SAS_STAT_OFF, 32'h0);
		rchk(`SAS_CMD_OFF, 32'h0);
		rchk(8'h14, 32'h0, `SAS_RESP_SLVERR);
		w(8'h14, 32'hffff_ffff, `SAS_RESP_SLVERR);
		// narrow, sign extend, saturate: negative saturation with capture
		w(`SAS_MODE_OFF, 32'h06);
		setacc(2, 40'h80_aa00_1234);
		w(`SAS_TREG_OFF, 32'h0005);
		w(`SAS_CMD_OFF, mk(2'h2, 2'h0, 1'b0, 1'b1, 1'b0, 6'h00));
		chkacc(2, 40'hff_8000_0000);
		rchk(`SAS_STAT_OFF, 32'h14);
		// capture right shift by immediate minus five into another accumulator
		w(`SAS_MODE_OFF, 32'h02);
		w(`SAS_STAT_OFF, 32'h3f);
		setacc(0, 40'hff_8765_0055);
		w(`SAS_CMD_OFF, mk(2'h0, 2'h1, 1'b1, 1'b1, 1'b1, 6'h3b));
		chkacc(1, 40'hff_fc3b_2802);
		chkacc(0, 40'hff_8765_0055);
		rchk(`SAS_STAT_OFF, 32'h10);
		// register amounts beyond range are clamped and flagged
		w(`SAS_MODE_OFF, 32'h01);
		w(`SAS_STAT_OFF, 32'h0f);
		setacc(0, 40'h00_0000_0001);
		w(`SAS_TREG_OFF, 32'h0040);
		w(`SAS_CMD_OFF, mk(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 6'h00));
		chkacc(0, 40'h00_8000_0000);
		rchk(`SAS_STAT_OFF, 32'h11);
		setacc(1, 40'h80_0000_0000);
		w(`SAS_TREG_OFF, 32'hff00);
		w(`SAS_CMD_OFF, mk(2'h1, 2'h0, 1'b0, 1'b0, 1'b0, 6'h00));
		chkacc(1, 40'hff_ffff_ff80);
		rchk(`SAS_STAT_OFF, 32'h13);
		// narrow without sign extension, then a zero count capture and a right shift
		w(`SAS_MODE_OFF, 32'h00);
		w(`SAS_STAT_OFF, 32'h3f);
		setacc(3, 40'hab_8000_0001);
		w(`SAS_CMD_OFF, mk(2'h3, 2'h0, 1'b0, 1'b1, 1'b1, 6'h01));
		chkacc(3, 40'h01_0000_0002);
		rchk(`SAS_STAT_OFF, 32'h18);
		w(`SAS_CMD_OFF, mk(2'h3, 2'h0, 1'b0, 1'b1, 1'b1, 6'h00));
		chkacc(3, 40'h00_0000_0002);
		rchk(`SAS_STAT_OFF, 32'h08);
		setacc(3, 40'hab_8000_0003);
		w(`SAS_CMD_OFF, mk(2'h3, 2'h0, 1'b0, 1'b1, 1'b1, 6'h3f));
		chkacc(3, 40'h00_4000_0001);
		rchk(`SAS_STAT_OFF, 32'h18);
		// saturation values in wide and narrow modes
		w(`SAS_MODE_OFF, 32'h05);
		w(`SAS_STAT_OFF, 32'h3f);
		setacc(0, 40'h40_0000_0000);
		w(`SAS_CMD_OFF, mk(2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 6'h01));
		chkacc(0, 40'h7f_ffff_ffff);
		setacc(2, 40'h80_0000_0000);
		// capture variant: wide left shift takes the carry from bit 39
		w(`SAS_CMD_OFF, mk(2'h2, 2'h0, 1'b0, 1'b1, 1'b1, 6'h01));
		chkacc(2, 40'h80_0000_0000);
		w(`SAS_MODE_OFF, 32'h04);
		setacc(1, 40'h00_4000_0000);
		w(`SAS_CMD_OFF, mk(2'h1, 2'h0, 1'b0, 1'b0, 1'b1, 6'h01));
		chkacc(1, 40'h00_7fff_ffff);
		rchk(`SAS_STAT_OFF, 32'h17);
		// legacy mode: wide behaviour, no overflow, folded amounts
		w(`SAS_MODE_OFF, 32'h0c);
		w(`SAS_STAT_OFF, 32'h3f);
		setacc(2, 40'h40_0000_0000);
		w(`SAS_TREG_OFF, 32'h0001);
		w(`SAS_CMD_OFF, mk(2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 6'h00));
		chkacc(2, 40'h80_0000_0000);
		setacc(3, 40'h12_0000_0000);
		w(`SAS_TREG_OFF, 32'h0020);
		w(`SAS_CMD_OFF, mk(2'h3, 2'h0, 1'b0, 1'b0, 1'b0, 6'h00));
		chkacc(3, 40'h00_0012_0000);
		rchk(`SAS_STAT_OFF, 32'h00);
		// single-bit shifts of the auxiliary register
		w(`SAS_MODE_OFF, 32'h10);
		w(`SAS_AUX_OFF, 32'hef27);
		w(`SAS_CMD_OFF, 32'h6000);
		rchk(`SAS_AUX_OFF, 32'hde4e);
		w(`SAS_AUX_OFF, 32'h4000);
		w(`SAS_CMD_OFF, 32'h6000);
		rchk(`SAS_AUX_OFF, 32'h7fff);
		w(`SAS_CMD_OFF, 32'h2000);
		rchk(`SAS_AUX_OFF, 32'h3fff);
		rchk(`SAS_STAT_OFF, 32'h20);
		final_report();
	end
endmodule
